/* File: pacc_pkg.sv */
// constants and types for the pulse accumulator and periodic interrupt block
package pacc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
   localparam logic [7:0] ADDR_FLAGS      = 8'h28;
   localparam logic [7:0] ADDR_CONTROL    = 8'h2C;
   localparam logic [7:0] ADDR_COUNT      = 8'h30;
   localparam int         ADDR_DECODE_W   = 8;

   ////////////////////////////////////////////////////////////////////////////
   // field positions shared by the enable and flag registers
   localparam int BIT_TIMER_OVF  = 7;
   localparam int BIT_PERIODIC   = 6;
   localparam int BIT_ACCUM_OVF  = 5;
   localparam int BIT_ACCUM_EDGE = 4;

   // field positions of the control register
   localparam int BIT_CTRL_ENABLE = 6;
   localparam int BIT_CTRL_MODE   = 5;
   localparam int BIT_CTRL_EDGE   = 4;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RST_FLAGS      = 8'h00;
   localparam logic [7:0] RST_CONTROL    = 8'h00;

   // writable bits; the others read zero
   localparam logic [7:0] MASK_IRQ_ENABLE = 8'hF3;
   localparam logic [7:0] MASK_FLAGS      = 8'hF0;
   localparam logic [7:0] MASK_CONTROL    = 8'h73;

   ////////////////////////////////////////////////////////////////////////////
   // timing counts in E clock cycles
   localparam int          PERIODIC_BASE_CYCLES = 8192;
   localparam int          PERIODIC_CNT_W       = 16;
   localparam int          GATED_DIV_CYCLES     = 64;
   localparam int          GATED_CNT_W          = 6;
   localparam logic [7:0]  COUNT_MAX            = 8'hFF;
   localparam logic [1:0]  HTRANS_NONSEQ_BIT    = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic {
      PACC_EVENT_COUNT = 1'b0,
      PACC_GATED_TIME  = 1'b1
   } pacc_mode_t;

   typedef struct packed {
      logic       timer_overflow_irq_enable;
      logic       periodic_irq_enable;
      logic       accum_overflow_irq_enable;
      logic       accum_edge_irq_enable;
      logic [1:0] unused;
      logic       timer_prescale_sel_hi;
      logic       timer_prescale_sel_lo;
   } pacc_irq_enable_t;

   typedef struct packed {
      logic       timer_overflow_flag;
      logic       periodic_flag;
      logic       accum_overflow_flag;
      logic       accum_edge_flag;
      logic [3:0] unused;
   } pacc_flags_t;

   typedef struct packed {
      logic       unused_hi;
      logic       accum_system_enable;
      pacc_mode_t accum_mode_select;
      logic       accum_edge_select;
      logic [1:0] unused_lo;
      logic [1:0] periodic_rate_select;
   } pacc_control_t;

   typedef struct packed {
      logic       write;
      logic       sel;
      logic [7:0] addr;
   } pacc_bus_phase_t;

endpackage

/* File: pacc_sync.sv */
// three-stage synchroniser with agreement filter for one asynchronous input
`timescale 1ns/100ps
module pacc_sync (
   input  wire logic clock_i,
   input  wire logic nrst_i,
   input  wire logic ce_i,
   input  wire logic async_i,
   output logic      level_o
);

   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;
   logic level_reg;

   // stage1 is read only by stage2
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
         level_reg  <= 1'b0;
      end else if (ce_i) begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin
            level_reg <= stage3_reg;
         end
      end
   end

   assign level_o = level_reg;

endmodule

/* File: pacc_top.sv */
// pulse accumulator and periodic interrupt with an ahb-lite register slave
`timescale 1ns/100ps
module pacc_top #(
   parameter int PERIODIC_BASE = pacc_pkg::PERIODIC_BASE_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // pin and neighbouring events
   input  wire logic        accum_input_pin_i,
   input  wire logic        timer_overflow_evt_i,
   // interrupt requests and prescale selection
   output logic             accum_overflow_irq_o,
   output logic             accum_edge_irq_o,
   output logic             periodic_irq_o,
   output logic             timer_overflow_irq_o,
   output logic [1:0]       timer_prescale_sel_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   pacc_pkg::pacc_irq_enable_t                  irq_enable_reg;
   pacc_pkg::pacc_flags_t                       flags_reg;
   pacc_pkg::pacc_control_t                     control_reg;
   logic [7:0]                                  accum_count_reg;
   pacc_pkg::pacc_bus_phase_t                   phase_reg;
   logic [31:0]                                 hrdata_reg;
   logic                                        accum_input_dly_reg;
   logic [pacc_pkg::PERIODIC_CNT_W-1:0]         periodic_base_reg;
   logic [2:0]                                  periodic_post_reg;
   logic [pacc_pkg::GATED_CNT_W-1:0]            gated_div_reg;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire        addr_take;
   wire [7:0]  addr_low;
   wire        wr_active;
   wire [7:0]  wr_byte;
   wire        wr_irq_enable;
   wire        wr_flags;
   wire        wr_control;
   wire        wr_count;
   wire [7:0]  rd_byte;
   wire [31:0] rd_word;

   assign addr_take = ce_i & hsel_i & hready_i & htrans_i[1];
   assign addr_low  = haddr_i[pacc_pkg::ADDR_DECODE_W-1:0];

   assign wr_active     = ce_i & phase_reg.sel & phase_reg.write;
   assign wr_byte       = hwdata_i[7:0];
   assign wr_irq_enable = wr_active & (phase_reg.addr == pacc_pkg::ADDR_IRQ_ENABLE);
   assign wr_flags      = wr_active & (phase_reg.addr == pacc_pkg::ADDR_FLAGS);
   assign wr_control    = wr_active & (phase_reg.addr == pacc_pkg::ADDR_CONTROL);
   assign wr_count      = wr_active & (phase_reg.addr == pacc_pkg::ADDR_COUNT);

   // unmapped addresses read zero
   assign rd_byte =
      (addr_low == pacc_pkg::ADDR_IRQ_ENABLE) ? irq_enable_reg :
      (addr_low == pacc_pkg::ADDR_FLAGS)      ? flags_reg :
      (addr_low == pacc_pkg::ADDR_CONTROL)    ? control_reg :
      (addr_low == pacc_pkg::ADDR_COUNT)      ? accum_count_reg :
      8'h00;
   assign rd_word = {24'h000000, rd_byte};

   // a read samples the count before the same edge's increment lands
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_reg  <= '0;
         hrdata_reg <= 32'h00000000;
      end else if (ce_i) begin
         if (hready_i) begin
            phase_reg.sel   <= addr_take;
            phase_reg.write <= hwrite_i;
            phase_reg.addr  <= addr_low;
         end
         if (addr_take & ~hwrite_i) begin
            hrdata_reg <= rd_word;
         end
      end
   end

   assign hrdata_o    = hrdata_reg;
   // zero wait states; a low clock enable stalls the bus rather than losing a transfer
   assign hreadyout_o = ce_i;
   assign hresp_o     = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // input pin conditioning

   wire accum_input;
   wire accum_rise;
   wire accum_fall;

   // three synchroniser flops and a level flop; a new level counts only once the last two stages agree
   pacc_sync u_input_sync (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .ce_i    (ce_i),
      .async_i (accum_input_pin_i),
      .level_o (accum_input)
   );

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         accum_input_dly_reg <= 1'b0;
      end else if (ce_i) begin
         accum_input_dly_reg <= accum_input;
      end
   end

   // one edge per E cycle at most; faster pin activity is filtered away
   assign accum_rise = accum_input & ~accum_input_dly_reg;
   assign accum_fall = ~accum_input & accum_input_dly_reg;

   ////////////////////////////////////////////////////////////////////////////
   // gated time prescaler, free running

   wire gated_tick;

   assign gated_tick =
      (gated_div_reg == pacc_pkg::GATED_CNT_W'(pacc_pkg::GATED_DIV_CYCLES - 1));

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gated_div_reg <= '0;
      end else if (ce_i) begin
         gated_div_reg <= gated_div_reg + pacc_pkg::GATED_CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator

   wire        acc_enabled;
   wire        acc_gated;
   wire        edge_selected;
   wire        level_counts;
   wire        count_event;
   wire        count_gated;
   wire        count_inc;
   wire        count_wrap;
   wire [7:0]  count_next;

   assign acc_enabled = control_reg.accum_system_enable;
   assign acc_gated   = (control_reg.accum_mode_select == pacc_pkg::PACC_GATED_TIME);

   // edge select 0 picks falling, 1 picks rising
   assign edge_selected = control_reg.accum_edge_select ? accum_rise : accum_fall;
   // in gated mode the level equal to edge select inhibits counting
   assign level_counts  = (accum_input != control_reg.accum_edge_select);

   assign count_event = acc_enabled & ~acc_gated & edge_selected;
   assign count_gated = acc_enabled & acc_gated & gated_tick & level_counts;
   assign count_inc   = count_event | count_gated;

   // a software write to the count wins over a same-cycle increment
   assign count_wrap = count_inc & ~wr_count & (accum_count_reg == pacc_pkg::COUNT_MAX);
   assign count_next = wr_count  ? wr_byte :
                       count_inc ? accum_count_reg + 8'h01 :
                       accum_count_reg;

   // the count has no reset so that it survives one
   always_ff @(posedge clock_i) begin
      if (ce_i) begin
         accum_count_reg <= count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // periodic interrupt divider

   wire       base_tick;
   wire [2:0] rate_mask;
   wire       periodic_evt;

   assign base_tick =
      (periodic_base_reg == pacc_pkg::PERIODIC_CNT_W'(PERIODIC_BASE - 1));

   // post divider of 1, 2, 4 or 8 base intervals
   assign rate_mask =
      (control_reg.periodic_rate_select == 2'h0) ? 3'h0 :
      (control_reg.periodic_rate_select == 2'h1) ? 3'h1 :
      (control_reg.periodic_rate_select == 2'h2) ? 3'h3 :
      3'h7;

   // flag clears never touch the divider, so service latency cannot stretch a period
   assign periodic_evt = base_tick & ((periodic_post_reg & rate_mask) == rate_mask);

   // only reset restarts the divider; no register access touches it
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         periodic_base_reg <= '0;
         periodic_post_reg <= 3'h0;
      end else if (ce_i) begin
         if (base_tick) begin
            periodic_base_reg <= '0;
            periodic_post_reg <= periodic_post_reg + 3'h1;
         end else begin
            periodic_base_reg <= periodic_base_reg + pacc_pkg::PERIODIC_CNT_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: set wins over write-one-clear

   wire [7:0] flag_set;
   wire [7:0] flag_clr;
   wire [7:0] flags_next;

   assign flag_set[pacc_pkg::BIT_TIMER_OVF]  = timer_overflow_evt_i;
   assign flag_set[pacc_pkg::BIT_PERIODIC]   = periodic_evt;
   assign flag_set[pacc_pkg::BIT_ACCUM_OVF]  = count_wrap;
   assign flag_set[pacc_pkg::BIT_ACCUM_EDGE] = acc_enabled & edge_selected;
   assign flag_set[3:0]                      = 4'h0;

   assign flag_clr   = wr_flags ? wr_byte : 8'h00;
   assign flags_next = ((flags_reg & ~flag_clr) | flag_set) & pacc_pkg::MASK_FLAGS;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags_reg <= pacc_pkg::RST_FLAGS;
      end else if (ce_i) begin
         flags_reg <= flags_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable and control registers

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_enable_reg <= pacc_pkg::RST_IRQ_ENABLE;
         control_reg    <= pacc_pkg::RST_CONTROL;
      end else if (ce_i) begin
         if (wr_irq_enable) begin
            irq_enable_reg <= wr_byte & pacc_pkg::MASK_IRQ_ENABLE;
         end
         if (wr_control) begin
            control_reg <= wr_byte & pacc_pkg::MASK_CONTROL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt requests, each enable paired with the flag at its bit

   wire [7:0] irq_pending;

   assign irq_pending = irq_enable_reg & flags_reg;

   assign accum_overflow_irq_o = irq_pending[pacc_pkg::BIT_ACCUM_OVF];
   assign accum_edge_irq_o     = irq_pending[pacc_pkg::BIT_ACCUM_EDGE];
   assign periodic_irq_o       = irq_pending[pacc_pkg::BIT_PERIODIC];
   assign timer_overflow_irq_o = irq_pending[pacc_pkg::BIT_TIMER_OVF];
   assign timer_prescale_sel_o = {irq_enable_reg.timer_prescale_sel_hi,
                                  irq_enable_reg.timer_prescale_sel_lo};

   ////////////////////////////////////////////////////////////////////////////
   // transfer size is not checked; byte lane 0 carries every register
   wire unused_ok;
   assign unused_ok = &{1'b0, hsize_i, haddr_i[31:8], hwdata_i[31:8], htrans_i[0]};

endmodule

/* File: pacc_pulse_src.sv */
// external event source that toggles the accumulator input pin
`timescale 1ns/100ps
module pacc_pulse_src (
   input  wire logic       clock_i,
   input  wire logic       go_i,
   input  wire logic [7:0] toggles_i,
   output logic            pin_o,
   output logic            busy_o
);
   logic [7:0] left;
   logic [1:0] gap;
   initial begin
      pin_o = 1'b0;
      left = 8'h00;
      gap = 2'h0;
   end
   // each level is held three cycles, slower than E/2
   always @(posedge clock_i) begin
      if (go_i && left == 8'h00) begin
         left <= toggles_i;
         gap <= 2'h2;
      end else if (left != 8'h00) begin
         if (gap == 2'h0) begin
            pin_o <= ~pin_o;
            left <= left - 8'h01;
            gap <= 2'h2;
         end else begin
            gap <= gap - 2'h1;
         end
      end
   end
   assign busy_o = (left != 8'h00);
endmodule

/* File: pacc_top_chk.sv */
// port assertions for the accumulator and periodic interrupt block
`timescale 1ns/100ps
module pacc_top_chk (
   input wire logic        clock_i,
   input wire logic        nrst_i,
   input wire logic        ce_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        timer_overflow_evt_i,
   input wire logic        accum_overflow_irq_o,
   input wire logic        accum_edge_irq_o,
   input wire logic        periodic_irq_o,
   input wire logic        timer_overflow_irq_o,
   input wire logic [1:0]  timer_prescale_sel_o
);
   logic       wr_q;
   logic [7:0] addr_q;
   logic       ten_q;
   wire        wr_dp  = wr_q & hready_i;
   wire        en_wr  = wr_dp & (addr_q == pacc_pkg::ADDR_IRQ_ENABLE);
   wire        flg_wr = wr_dp & (addr_q == pacc_pkg::ADDR_FLAGS);
   // track write data phases to know the enables
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         ten_q <= 1'b0;
      end else if (hready_i) begin
         wr_q <= hsel_i & htrans_i[1] & hwrite_i;
         addr_q <= haddr_i[7:0];
         if (en_wr) ten_q <= hwdata_i[7];
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   chk_resp_okay: assert property (hresp_o == 1'b0)
      else $error("response not okay");
   chk_ready_ce: assert property (hreadyout_o == ce_i)
      else $error("ready does not follow enable");
   chk_rdata_upper: assert property (hrdata_o[31:8] == 24'h000000)
      else $error("upper read data not zero");
   chk_prescale_wr: assert property (
      en_wr |=> timer_prescale_sel_o == $past(hwdata_i[1:0]))
      else $error("prescale select not written");
   chk_ovf_gate: assert property (en_wr && !hwdata_i[5] |=> !accum_overflow_irq_o)
      else $error("overflow request not masked");
   chk_edge_gate: assert property (en_wr && !hwdata_i[4] |=> !accum_edge_irq_o)
      else $error("edge request not masked");
   chk_per_gate: assert property (en_wr && !hwdata_i[6] |=> !periodic_irq_o)
      else $error("periodic request not masked");
   chk_tovf_set: assert property (
      timer_overflow_evt_i && ten_q && ce_i && !en_wr |=> timer_overflow_irq_o)
      else $error("timer overflow request missing");
   chk_tovf_hold: assert property (
      timer_overflow_irq_o && !(flg_wr && hwdata_i[7]) && !en_wr |=> timer_overflow_irq_o)
      else $error("timer overflow request lost");
   // read data stands until the next read address phase is taken
   chk_rdata_hold: assert property (
      !(hsel_i && htrans_i[1] && !hwrite_i && hready_i) |=> $stable(hrdata_o))
      else $error("read data changed without a read");
   cover property (en_wr && hwdata_i[6]);
   cover property (periodic_irq_o);
   cover property (accum_overflow_irq_o && accum_edge_irq_o);
   cover property (flg_wr && hwdata_i[7]);
endmodule
bind pacc_top pacc_top_chk CHK (.clock_i, .nrst_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
   .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .timer_overflow_evt_i,
   .accum_overflow_irq_o, .accum_edge_irq_o, .periodic_irq_o, .timer_overflow_irq_o,
   .timer_prescale_sel_o);

/* File: test_pacc_top.sv */
// self-checking bench for the accumulator and periodic interrupt block
`timescale 1ns/100ps
module test_pacc_top;
   localparam logic [7:0] AE = pacc_pkg::ADDR_IRQ_ENABLE;
   localparam logic [7:0] AF = pacc_pkg::ADDR_FLAGS;
   localparam logic [7:0] AC = pacc_pkg::ADDR_CONTROL;
   localparam logic [7:0] AN = pacc_pkg::ADDR_COUNT;
   logic        clock_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        ce = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        tevt = 1'b0;
   logic        go = 1'b0;
   logic [7:0]  tog = 8'h00;
   wire         pin, busy, hready, hresp, i_ov, i_ed, i_pe, i_to;
   wire  [31:0] hrdata;
   wire  [1:0]  psel;
   logic [31:0] rd;
   int          fails = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          t1;
   always #10 clock_i = ~clock_i;
   always @(negedge clock_i) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         report_and_stop;
      end
   end
   pacc_pulse_src SRC (.clock_i(clock_i), .go_i(go), .toggles_i(tog), .pin_o(pin),
      .busy_o(busy));
   pacc_top #(.PERIODIC_BASE(16)) DUT (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .accum_input_pin_i(pin),
      .timer_overflow_evt_i(tevt), .accum_overflow_irq_o(i_ov), .accum_edge_irq_o(i_ed),
      .periodic_irq_o(i_pe), .timer_overflow_irq_o(i_to), .timer_prescale_sel_o(psel));
   ////////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task st;
      @(negedge clock_i);
   endtask
   task pulse(input logic [7:0] n);
      @(posedge clock_i);
      tog <= n;
      go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      do @(posedge clock_i); while (busy === 1'b1);
      repeat (8) @(posedge clock_i);
   endtask
   task rise;
      do @(posedge clock_i); while (i_pe !== 1'b1);
   endtask
   task report_and_stop;
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      wr(AN, 32'h0);
      rc(AE, 32'hFF, 32'h00);
      rc(AC, 32'hFF, 32'h00);
      wr(AE, 32'hFF);
      rc(AE, 32'hFF, 32'hF3);
      chk(32'(psel), 32'h3);
      chk(32'(hresp), 32'h0);
      wr(AC, 32'hFF);
      rc(AC, 32'hFF, 32'h73);
      wr(8'h3C, 32'hFF);
      rc(8'h3C, 32'hFF, 32'h00);
      wr(AE, 32'h00);
      wr(AC, 32'h00);
      rc(AF, 32'hFF, 32'h40);
      chk(32'(i_pe), 32'h0);
      ce <= 1'b0;
      st;
      chk(32'(hready), 32'h0);
      @(posedge clock_i);
      ce <= 1'b1;
   endtask
   task t_edges;
      for (int e = 0; e < 2; e++) begin
         wr(AC, 32'h40 | 32'(e << 4));
         wr(AN, 32'h0);
         pulse(8'h01);
         rc(AN, 32'hFF, 32'(e));
         pulse(8'h01);
         rc(AN, 32'hFF, 32'h1);
      end
      wr(AC, 32'h10);
      pulse(8'h02);
      rc(AN, 32'hFF, 32'h1);
   endtask
   task t_ovf;
      wr(AC, 32'h50);
      wr(AN, 32'hFE);
      wr(AF, 32'h30);
      pulse(8'h04);
      rc(AN, 32'hFF, 32'h00);
      rc(AF, 32'h30, 32'h30);
      chk(32'(i_ov), 32'h0);
      chk(32'(i_ed), 32'h0);
      wr(AE, 32'h30);
      st;
      chk(32'(i_ov), 32'h1);
      chk(32'(i_ed), 32'h1);
      wr(AF, 32'h00);
      rc(AF, 32'h30, 32'h30);
      wr(AF, 32'h20);
      st;
      chk(32'(i_ov), 32'h0);
      chk(32'(i_ed), 32'h1);
      wr(AF, 32'h10);
      st;
      chk(32'(i_ed), 32'h0);
   endtask
   task t_gated;
      logic [31:0] c;
      wr(AC, 32'h70);
      wr(AN, 32'h0);
      repeat (640) @(posedge clock_i);
      bus(1'b0, AN, 32'h0);
      chk(32'(rd[7:0] >= 8'h0A && rd[7:0] <= 8'h0B), 32'h1);
      pulse(8'h01);
      bus(1'b0, AN, 32'h0);
      c = rd;
      repeat (320) @(posedge clock_i);
      rc(AN, 32'hFF, c & 32'hFF);
      pulse(8'h01);
      wr(AC, 32'h00);
   endtask
   task t_per;
      wr(AE, 32'h40);
      for (int r = 0; r < 4; r++) begin
         wr(AC, 32'(r));
         repeat (2) begin
            rise;
            wr(AF, 32'h40);
         end
         rise;
         t1 = cyc;
         wr(AF, 32'h40);
         repeat (r * 5) @(posedge clock_i);
         rise;
         chk(32'(cyc - t1), 32'(16 << r));
      end
      wr(AC, 32'h00);
   endtask
   task t_tovf;
      wr(AE, 32'h80);
      @(posedge clock_i);
      tevt <= 1'b1;
      @(posedge clock_i);
      tevt <= 1'b0;
      st;
      chk(32'(i_to), 32'h1);
      rc(AF, 32'h80, 32'h80);
      wr(AF, 32'h80);
      st;
      chk(32'(i_to), 32'h0);
   endtask
   task t_reset;
      wr(AN, 32'h5A);
      wr(AE, 32'h83);
      @(posedge clock_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      t1 = cyc;
      st;
      chk(32'(psel), 32'h0);
      rc(AN, 32'hFF, 32'h5A);
      rc(AE, 32'hFF, 32'h00);
      wr(AE, 32'h40);
      rise;
      chk(32'(cyc - t1 >= 16 && cyc - t1 <= 18), 32'h1);
   endtask
   initial begin
      repeat (5) @(posedge clock_i);
      nrst_i <= 1'b1;
      t_regs;
      t_edges;
      t_ovf;
      t_gated;
      t_per;
      t_tovf;
      t_reset;
      report_and_stop;
   end
endmodule
